// >>> flash_boot_pkg.sv
package flash_boot_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ==========================================================================
  // Register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFFS   = 8'h00;
  localparam logic [ADDR_W-1:0] MODE_OFFS   = 8'h04;
  localparam logic [ADDR_W-1:0] FADDR_OFFS  = 8'h08;
  localparam logic [ADDR_W-1:0] FDATA_OFFS  = 8'h0c;
  localparam logic [ADDR_W-1:0] CMD_OFFS    = 8'h10;
  localparam logic [ADDR_W-1:0] STATUS_OFFS = 8'h14;
  localparam logic [ADDR_W-1:0] BOUND_OFFS  = 8'h18;

  // ==========================================================================
  // Control register fields
  localparam int EN_BIT   = 7;
  localparam int BOOT_BIT = 6;
  localparam int RST_BIT  = 5;
  localparam int FAIL_BIT = 4;

  // ==========================================================================
  // Command keys, mode codes and reset values
  localparam logic [7:0]  CMD_KEY1        = 8'h46;
  localparam logic [7:0]  CMD_KEY2        = 8'hb9;
  localparam logic [3:0]  MODE_STANDBY    = 4'h0;
  localparam logic [3:0]  MODE_READ       = 4'h1;
  localparam logic [3:0]  MODE_PROGRAM    = 4'h2;
  localparam logic [3:0]  MODE_ERASE      = 4'h3;
  localparam logic [3:0]  MODE_SP_WRITE   = 4'h4;
  localparam logic [3:0]  MODE_SP_READ    = 4'h5;
  localparam logic [15:0] DF_TOP_NOLOADER = 16'h7fff;
  localparam logic [7:0]  FDATA_RESET     = 8'hff;
  localparam logic [7:0]  SP_BOUND_IDX    = 8'h03;
  localparam logic [15:0] PAGE_MASK       = 16'hfe00;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef enum logic [1:0] {ENG_IDLE, ENG_ARRAY, ENG_SPECIAL} engine_state_t;

endpackage : flash_boot_pkg

// >>> special_page_mem.sv
`timescale 1ns/10ps
module special_page_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 256
) (
  // Clock
  input  wire logic                     ref_clk,
  // Access port
  input  wire logic                     en,
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] addr,
  input  wire logic [WIDTH-1:0]         wdata,
  output logic      [WIDTH-1:0]         rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  // ==========================================================================
  // Registered read, write-first not needed: one access per request
  always_ff @(posedge ref_clk)
  begin
    if (en && we)
    begin
      mem[addr] <= wdata;
    end
    if (en)
    begin
      rdata <= mem[addr];
    end
  end

endmodule : special_page_mem

// >>> flash_prog_boot_ctrl.sv
// Contract
// - Soft reset with boot-select clear restarts application
// - Hardware option boots loader after power-on
// - Second option also boots loader after external reset
// - Pattern 111 from application reboots into loader
// - Loader start address applied as code offset
// - Flash operation halts CPU, interrupts held pending
// - CPU frozen, resumes at following instruction
// - Loader context: destination above data flash ignored
// - Application context: destination outside data flash ignored
// - Loader code never modifies loader region
// - Application code programs only data flash
// - Loader present: data flash ends below loader
// - No loader: data flash ends at 7fff
// - Low bound from rewritable low-boundary register
// - Low boundary resets to programmer configuration
// - Direct code reads return data flash contents
// - Key 46 then b9 triggers when enabled
// - Control bits: enable, boot select, self-clearing reset
// - Mode codes zero through five
// - Fail flag set on refusal, cleared on success
`timescale 1ns/10ps
module flash_prog_boot_ctrl #(
  parameter int SP_DEPTH = 256
) (
  // Clock and reset
  input  wire logic                                ref_clk,
  input  wire logic                                reset_n,
  // AXI4-Lite write channels
  input  wire logic [flash_boot_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                                s_axi_awvalid,
  output logic                                     s_axi_awready,
  input  wire logic [flash_boot_pkg::DATA_W-1:0]   s_axi_wdata,
  input  wire logic [flash_boot_pkg::DATA_W/8-1:0] s_axi_wstrb,
  input  wire logic                                s_axi_wvalid,
  output logic                                     s_axi_wready,
  output logic [1:0]                               s_axi_bresp,
  output logic                                     s_axi_bvalid,
  input  wire logic                                s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [flash_boot_pkg::ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                                s_axi_arvalid,
  output logic                                     s_axi_arready,
  output logic [flash_boot_pkg::DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]                               s_axi_rresp,
  output logic                                     s_axi_rvalid,
  input  wire logic                                s_axi_rready,
  // Hardware options and reset causes
  input  wire logic                                hwLoaderBootOption,
  input  wire logic                                hwLoaderBootOnExtResetOption,
  input  wire logic                                loaderPresent,
  input  wire logic [15:0]                         loaderStart,
  input  wire logic [7:0]                          storedLowBoundary,
  input  wire logic                                porFlag,
  input  wire logic                                extResetFlag,
  // CPU side
  output logic                                     cpuStall,
  output logic                                     softResetReq,
  output logic                                     bootFromLoader,
  output logic [15:0]                              codeOffset,
  input  wire logic                                codeRdEn,
  input  wire logic [15:0]                         codeRdAddr,
  output logic [7:0]                               codeRdData,
  output logic                                     codeRdValid,
  // Flash array side
  output logic                                     arrayReq,
  output logic [1:0]                               arrayOp,
  output logic [15:0]                              arrayAddr,
  output logic [7:0]                               arrayWdata,
  input  wire logic                                arrayDone,
  input  wire logic [7:0]                          arrayRdata,
  output logic [15:0]                              arrayDirectAddr,
  input  wire logic [7:0]                          arrayDirectData
);
  import flash_boot_pkg::*;

  // ==========================================================================
  // Address decode
  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    isMapped = (a == CTRL_OFFS) || (a == MODE_OFFS) || (a == FADDR_OFFS) ||
               (a == FDATA_OFFS) || (a == CMD_OFFS) || (a == STATUS_OFFS) ||
               (a == BOUND_OFFS);
  endfunction : isMapped

  // ==========================================================================
  // AXI4-Lite slave
  logic [ADDR_W-1:0]   awAddr, next_awAddr, next_araddrHold;
  logic [DATA_W-1:0]   wData, next_wData, next_rdata;
  logic [DATA_W/8-1:0] wStrb, next_wStrb;
  logic                awHeld, next_awHeld, wHeld, next_wHeld;
  logic                next_bvalid, next_rvalid, next_arready;
  logic [1:0]          next_bresp, next_rresp;
  logic                doWrite;
  logic [DATA_W-1:0]   readMux;

  assign doWrite = awHeld && wHeld && !s_axi_bvalid;
  assign next_araddrHold = s_axi_araddr;

  always_comb
  begin
    next_awAddr  = awAddr;
    next_wData   = wData;
    next_wStrb   = wStrb;
    next_awHeld  = awHeld;
    next_wHeld   = wHeld;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_rvalid  = s_axi_rvalid;
    next_rresp   = s_axi_rresp;
    next_rdata   = s_axi_rdata;
    next_arready = s_axi_arready;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_awHeld = 1'b1;
      next_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_wHeld = 1'b1;
      next_wData = s_axi_wdata;
      next_wStrb = s_axi_wstrb;
    end
    if (doWrite)
    begin
      next_awHeld = 1'b0;
      next_wHeld  = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = isMapped(awAddr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_axi_bvalid && s_axi_bready)
    begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_arready = 1'b0;
      next_rvalid  = 1'b1;
      next_rdata   = readMux;
      next_rresp   = isMapped(next_araddrHold) ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_axi_rvalid && s_axi_rready)
    begin
      next_rvalid  = 1'b0;
      next_arready = 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      awAddr        <= '0;
      wData         <= '0;
      wStrb         <= '0;
      awHeld        <= 1'b0;
      wHeld         <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_rdata   <= '0;
    end
    else
    begin
      awAddr        <= next_awAddr;
      wData         <= next_wData;
      wStrb         <= next_wStrb;
      awHeld        <= next_awHeld;
      wHeld         <= next_wHeld;
      s_axi_awready <= !next_awHeld;
      s_axi_wready  <= !next_wHeld;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_arready <= next_arready || (!s_axi_arready && !s_axi_rvalid);
      s_axi_rvalid  <= next_rvalid;
      s_axi_rresp   <= next_rresp;
      s_axi_rdata   <= next_rdata;
    end
  end

  // ==========================================================================
  // Flash sequencer state
  logic          enable, softBoot, failFlag, armed, resetSeen;
  logic [3:0]    mode;
  logic [15:0]   flashAddr;
  logic [7:0]    dataReg, lowBoundary;
  engine_state_t state, next_state;
  logic          next_enable, next_softBoot, next_failFlag, next_armed, next_cpuStall;
  logic [3:0]    next_mode;
  logic [15:0]   next_flashAddr, next_arrayAddr;
  logic [7:0]    next_dataReg, next_lowBoundary, next_arrayWdata;
  logic          next_softResetReq, next_arrayReq, next_spEn, next_spWe;
  logic [1:0]    next_arrayOp;
  logic          softLatchValid, softLatchSel, next_softLatchValid, next_softLatchSel;
  logic          spWe;
  logic [7:0]    spAddr, spWdata, spRdata;
  logic [15:0]   dfHigh, dfLow;
  logic          wrLane0, cmdTrig, arrayMode, spMode, destOk, accepted, bootDecision;

  assign dfHigh = loaderPresent ? loaderStart - 16'h0001 : DF_TOP_NOLOADER;
  assign dfLow  = {lowBoundary, 8'h00};
  assign wrLane0   = doWrite && wStrb[0];
  assign cmdTrig   = wrLane0 && (awAddr == CMD_OFFS) && armed && (wData[7:0] == CMD_KEY2);
  assign arrayMode = (mode == MODE_READ) || (mode == MODE_PROGRAM) || (mode == MODE_ERASE);
  assign spMode    = (mode == MODE_SP_WRITE) || (mode == MODE_SP_READ);
  // Loader may reach everything below the loader, application only data flash
  assign destOk = arrayMode ? (bootFromLoader ? (flashAddr <= dfHigh)
                                              : (flashAddr >= dfLow && flashAddr <= dfHigh))
                            : (spMode && flashAddr[15:8] == 8'h00);
  assign accepted = cmdTrig && enable && destOk && (state == ENG_IDLE);
  assign bootDecision = loaderPresent && ((porFlag && hwLoaderBootOption)
                        || (extResetFlag && hwLoaderBootOption && hwLoaderBootOnExtResetOption)
                        || (softLatchValid && softLatchSel));

  always_comb
  begin
    next_state          = state;
    next_enable         = enable;
    next_softBoot       = softBoot;
    next_failFlag       = failFlag;
    next_armed          = armed;
    next_mode           = mode;
    next_flashAddr      = flashAddr;
    next_dataReg        = dataReg;
    next_lowBoundary    = lowBoundary;
    next_cpuStall       = cpuStall;
    next_softResetReq   = 1'b0;
    next_arrayReq       = arrayReq;
    next_arrayOp        = arrayOp;
    next_arrayAddr      = arrayAddr;
    next_arrayWdata     = arrayWdata;
    next_spEn           = 1'b0;
    next_spWe           = 1'b0;
    next_softLatchValid = softLatchValid;
    next_softLatchSel   = softLatchSel;
    if (wrLane0)
    begin
      case (awAddr)
        CTRL_OFFS:
        begin
          next_enable   = wData[EN_BIT];
          next_softBoot = wData[BOOT_BIT];
          next_failFlag = wData[FAIL_BIT];
          if (wData[RST_BIT])
          begin
            next_softResetReq   = 1'b1;
            next_softLatchValid = 1'b1;
            next_softLatchSel   = wData[BOOT_BIT];
          end
        end
        MODE_OFFS:  next_mode = wData[3:0];
        FADDR_OFFS: next_flashAddr[7:0] = wData[7:0];
        FDATA_OFFS: next_dataReg = wData[7:0];
        default:    next_mode = mode;
      endcase
      if (awAddr == CMD_OFFS)
      begin
        next_armed = (wData[7:0] == CMD_KEY1);
      end
    end
    if (doWrite && wStrb[1] && awAddr == FADDR_OFFS)
    begin
      next_flashAddr[15:8] = wData[15:8];
    end
    case (state)
      ENG_IDLE:
      begin
        if (accepted && arrayMode)
        begin
          next_state      = ENG_ARRAY;
          next_cpuStall   = 1'b1;
          next_arrayReq   = 1'b1;
          next_arrayOp    = mode[1:0];
          next_arrayAddr  = (mode == MODE_ERASE) ? (flashAddr & PAGE_MASK) : flashAddr;
          next_arrayWdata = dataReg;
        end
        else if (accepted)
        begin
          next_state    = ENG_SPECIAL;
          next_cpuStall = 1'b1;
          next_spEn     = 1'b1;
          next_spWe     = (mode == MODE_SP_WRITE);
        end
      end
      ENG_ARRAY:
      begin
        if (arrayDone)
        begin
          next_state    = ENG_IDLE;
          next_cpuStall = 1'b0;
          next_arrayReq = 1'b0;
          next_failFlag = 1'b0;
          if (arrayOp == MODE_READ[1:0])
          begin
            next_dataReg = arrayRdata;
          end
        end
      end
      ENG_SPECIAL:
      begin
        next_state    = ENG_IDLE;
        next_cpuStall = 1'b0;
        next_failFlag = 1'b0;
        if (spAddr == SP_BOUND_IDX)
        begin
          if (spWe)
          begin
            next_lowBoundary = {spWdata[7:1], 1'b0};
          end
          else
          begin
            next_dataReg = lowBoundary;
          end
        end
        else if (!spWe)
        begin
          next_dataReg = spRdata;
        end
      end
      default: next_state = ENG_IDLE;
    endcase
    // A refusal wins over a completion clear in the same cycle
    if (cmdTrig && !accepted)
    begin
      next_failFlag = 1'b1;
    end
    if (reset_n && !resetSeen)
    begin
      next_softLatchValid = 1'b0;
      next_lowBoundary    = storedLowBoundary;
    end
  end

  // Soft boot choice must survive the reset it causes; power-on clears it, the valid bit also clears once the boot decision is taken
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      if (porFlag)
      begin
        softLatchValid <= 1'b0;
        softLatchSel   <= 1'b0;
      end
    end
    else
    begin
      softLatchValid <= next_softLatchValid;
      softLatchSel   <= next_softLatchSel;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      state          <= ENG_IDLE;
      enable         <= 1'b0;
      softBoot       <= 1'b0;
      failFlag       <= 1'b0;
      armed          <= 1'b0;
      mode           <= MODE_STANDBY;
      flashAddr      <= '0;
      dataReg        <= FDATA_RESET;
      lowBoundary    <= '0;
      cpuStall       <= 1'b0;
      softResetReq   <= 1'b0;
      arrayReq       <= 1'b0;
      arrayOp        <= '0;
      arrayAddr      <= '0;
      arrayWdata     <= '0;
      spWe           <= 1'b0;
      spAddr         <= '0;
      spWdata        <= '0;
      resetSeen      <= 1'b0;
      bootFromLoader <= 1'b0;
      codeOffset     <= '0;
    end
    else
    begin
      state        <= next_state;
      enable       <= next_enable;
      softBoot     <= next_softBoot;
      failFlag     <= next_failFlag;
      armed        <= next_armed;
      mode         <= next_mode;
      flashAddr    <= next_flashAddr;
      dataReg      <= next_dataReg;
      lowBoundary  <= next_lowBoundary;
      cpuStall     <= next_cpuStall;
      softResetReq <= next_softResetReq;
      arrayReq     <= next_arrayReq;
      arrayOp      <= next_arrayOp;
      arrayAddr    <= next_arrayAddr;
      arrayWdata   <= next_arrayWdata;
      spWe         <= next_spWe;
      spAddr       <= next_spEn ? flashAddr[7:0] : spAddr;
      spWdata      <= next_spEn ? dataReg : spWdata;
      resetSeen    <= 1'b1;
      if (!resetSeen)
      begin
        bootFromLoader <= bootDecision;
        codeOffset     <= bootDecision ? loaderStart : 16'h0000;
      end
    end
  end

  special_page_mem #(
    .WIDTH (8),
    .DEPTH (SP_DEPTH)
  ) u_special_page (
    .ref_clk (ref_clk),
    .en      (next_spEn),
    .we      (next_spWe),
    .addr    (flashAddr[$clog2(SP_DEPTH)-1:0]),
    .wdata   (dataReg),
    .rdata   (spRdata)
  );

  // ==========================================================================
  // Direct code-space reads of data flash
  logic dirPend, dirOk;

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      dirPend         <= 1'b0;
      dirOk           <= 1'b0;
      arrayDirectAddr <= '0;
      codeRdData      <= '0;
      codeRdValid     <= 1'b0;
    end
    else
    begin
      dirPend     <= codeRdEn;
      dirOk       <= codeRdAddr >= dfLow && codeRdAddr <= dfHigh;
      codeRdValid <= dirPend;
      if (codeRdEn)
      begin
        arrayDirectAddr <= codeRdAddr;
      end
      if (dirPend)
      begin
        codeRdData <= dirOk ? arrayDirectData : 8'h00;
      end
    end
  end

  // ==========================================================================
  // Register read view
  always_comb
  begin
    readMux = '0;
    case (s_axi_araddr)
      CTRL_OFFS:   readMux[7:0] = {enable, softBoot, 1'b0, failFlag, 4'h0};
      MODE_OFFS:   readMux[3:0] = mode;
      FADDR_OFFS:  readMux[15:0] = flashAddr;
      FDATA_OFFS:  readMux[7:0] = dataReg;
      STATUS_OFFS: readMux[2:0] = {cpuStall, armed, bootFromLoader};
      BOUND_OFFS:  readMux[7:0] = lowBoundary;
      default:     readMux = '0;
    endcase
  end

  // ==========================================================================
  // Checks
  sequence keyTrigger;
    cmdTrig && enable;
  endsequence

  stall_start_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    accepted |=> cpuStall && state != ENG_IDLE)
    else $error("stall not raised after trigger");
  stall_end_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state == ENG_ARRAY && arrayDone && !cmdTrig) |=> !cpuStall && !arrayReq && !failFlag)
    else $error("stall not dropped at completion");
  loader_dest_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (keyTrigger and (bootFromLoader && arrayMode && flashAddr > dfHigh)) |=> !cpuStall && failFlag)
    else $error("loader trigger above data flash acted");
  app_dest_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (cmdTrig && !bootFromLoader && arrayMode && (flashAddr < dfLow || flashAddr > dfHigh))
      |=> !cpuStall && !arrayReq && failFlag)
    else $error("application trigger outside data flash acted");
  disabled_cmd_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (cmdTrig && !enable) |=> !cpuStall ##1 !cpuStall)
    else $error("trigger acted while disabled");
  soft_pulse_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (wrLane0 && awAddr == CTRL_OFFS && wData[RST_BIT]) |=> softResetReq ##1 !softResetReq)
    else $error("soft reset request not a single pulse");
  boot_choice_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!resetSeen && porFlag && hwLoaderBootOption && loaderPresent)
      |=> bootFromLoader && codeOffset == $past(loaderStart))
    else $error("boot region or code offset wrong");
  bound_load_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!resetSeen) |=> lowBoundary == $past(storedLowBoundary))
    else $error("low boundary not loaded from configuration");
  direct_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (dirPend && !dirOk) |=> codeRdValid && codeRdData == 8'h00)
    else $error("out of range direct read not blanked");

endmodule : flash_prog_boot_ctrl

// >>> flash_array_model.sv
`timescale 1ns/10ps
module flash_array_model (
  // Request side
  input  wire logic        ref_clk,
  input  wire logic        arrayReq,
  input  wire logic [1:0]  arrayOp,
  input  wire logic [15:0] arrayAddr,
  input  wire logic [7:0]  arrayWdata,
  input  wire logic [3:0]  lat,
  output logic             arrayDone,
  output logic [7:0]       arrayRdata,
  // Direct read side
  input  wire logic [15:0] arrayDirectAddr,
  output logic [7:0]       arrayDirectData
);
  // =====
  // Array storage, erased state is all ones
  logic [7:0] mem [0:65535];
  logic [3:0] cnt;
  initial
  begin
    foreach (mem[i]) mem[i] = 8'hff;
    cnt = 4'h0;
    arrayDone = 1'b0;
    arrayRdata = 8'h5a;
  end
  assign arrayDirectData = mem[arrayDirectAddr];
  // Read data is only valid with the done pulse
  always @(posedge ref_clk)
  begin
    arrayDone <= 1'b0;
    arrayRdata <= ~arrayRdata;
    if (arrayReq && !arrayDone)
      if (cnt != lat) cnt <= cnt + 4'h1;
      else
      begin
        cnt <= 4'h0;
        arrayDone <= 1'b1;
        arrayRdata <= mem[arrayAddr];
        // Programming only clears bits
        if (arrayOp == 2'h2) mem[arrayAddr] <= mem[arrayAddr] & arrayWdata;
        if (arrayOp == 2'h3) for (int i = 0; i < 512; i++) mem[{arrayAddr[15:9], i[8:0]}] <= 8'hff;
      end
  end
endmodule : flash_array_model

// >>> flash_prog_boot_ctrl_tb.sv
`timescale 1ns/10ps
module flash_prog_boot_ctrl_tb;
  import flash_boot_pkg::*;
  // =====
  // Stimulus and observation
  logic ref_clk = 0, reset_n = 0, porFlag = 1, extResetFlag = 0, codeRdEn = 0, en = 1;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, storedLowBoundary = 8'h78;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0, loaderPresent = 1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, arrayOp;
  logic hwLoaderBootOption = 0, hwLoaderBootOnExtResetOption = 0;
  logic cpuStall, softResetReq, bootFromLoader, codeRdValid, arrayReq, arrayDone;
  logic [15:0] codeOffset, arrayAddr, arrayDirectAddr, codeRdAddr = 0, dfLow = 16'h7800;
  logic [7:0] codeRdData, arrayWdata, arrayRdata, arrayDirectData;
  logic [3:0] lat = 0;
  int seed = 32'hb5a393a9, badCount = 0, totalChecks = 0, cyc = 0, stallN = 0, srN = 0;
  localparam logic [15:0] LDR = 16'h7c00;
  logic [3:0] tm [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h1, 4'h1, 4'h2};
  logic [15:0] ta [10] = '{16'h7900, 16'h7900, 16'h7901, 16'h7a00, 16'h0010, 16'h0010,
                           16'h7900, 16'h7c00, 16'h77ff, 16'h0100};
  flash_prog_boot_ctrl flash_prog_boot_ctrl_inst (.ref_clk, .reset_n, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'b1), .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready(1'b1), .hwLoaderBootOption, .hwLoaderBootOnExtResetOption, .loaderPresent,
    .loaderStart(LDR), .storedLowBoundary, .porFlag, .extResetFlag, .cpuStall, .softResetReq,
    .bootFromLoader, .codeOffset, .codeRdEn, .codeRdAddr, .codeRdData, .codeRdValid,
    .arrayReq, .arrayOp, .arrayAddr, .arrayWdata, .arrayDone, .arrayRdata, .arrayDirectAddr,
    .arrayDirectData);
  flash_array_model flash_array_model_inst (.ref_clk, .arrayReq, .arrayOp, .arrayAddr,
    .arrayWdata, .lat, .arrayDone, .arrayRdata, .arrayDirectAddr, .arrayDirectData);
  initial forever #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cpuStall === 1'b1) stallN <= stallN + 1;
    if (softResetReq === 1'b1) srN <= srN + 1;
    if (cyc == 20000) begin badCount++; testDone; end
  end
  // =====
  // Tasks
  task automatic testDone;
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : testDone
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    totalChecks++;
    if (g !== e) begin badCount++; $display("[ERR] %s exp %h got %h", n, e, g); end
  endtask : chk
  task automatic rst(input logic p, input logic e);
    reset_n <= 0; porFlag <= p; extResetFlag <= e;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1;
    @(posedge ref_clk);
    porFlag <= 0; extResetFlag <= 0;
    @(posedge ref_clk);
  endtask : rst
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
    forever begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid === 1'b1) begin chk("bresp", RESP_OKAY, s_axi_bresp); break; end
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a; s_axi_arvalid <= 1;
    forever begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid === 1'b1) begin d = s_axi_rdata; r = s_axi_rresp; break; end
    end
  endtask : rd
  task automatic op(input logic ldr, input logic [3:0] m, input logic [15:0] a,
                    input logic [7:0] d);
    logic [31:0] v;
    logic [1:0] r;
    logic ok;
    ok = en && m != 0 && m < 6 && (m > 3 ? a[15:8] == 0 : a < LDR && (ldr || a >= dfLow));
    lat <= 4'($random(seed));
    wr(MODE_OFFS, {28'h0, m}); wr(FADDR_OFFS, {16'h0, a}); wr(FDATA_OFFS, {24'h0, d});
    stallN = 0;
    wr(CMD_OFFS, 32'h46); wr(CMD_OFFS, 32'hb9);
    while (cpuStall) @(posedge ref_clk);
    rd(CTRL_OFFS, v, r);
    chk("fail", !ok, v[FAIL_BIT]);
    chk("stalled", ok, stallN > 0);
    if (ok && m > 3) chk("stall1", 1, stallN);
  endtask : op
  task automatic dread(input logic [15:0] a, output logic [7:0] g);
    g = 8'hxx; codeRdAddr <= a; codeRdEn <= 1;
    @(posedge ref_clk);
    codeRdEn <= 0;
    repeat (4) begin @(posedge ref_clk); if (codeRdValid === 1'b1) g = codeRdData; end
  endtask : dread
  initial
  begin
    logic [31:0] v; logic [1:0] r; logic [15:0] a; logic [7:0] d, g;
    rst(1, 0);
    rd(BOUND_OFFS, v, r); chk("bound", 32'h78, v);
    rd(FDATA_OFFS, v, r); chk("fdata", 32'hff, v);
    rd(8'h1c, v, r); chk("unmapped", RESP_SLVERR, r);
    chk("boot", 0, {bootFromLoader, codeOffset});
    wr(CTRL_OFFS, 32'h80);
    op(0, MODE_ERASE, 16'h7800, 8'h0);
    for (int i = 0; i < 6; i++) begin
      a = 16'h7800 + 16'(i * 4) + 16'($random(seed) & 3); d = 8'($random(seed));
      op(0, MODE_PROGRAM, a, d); op(0, MODE_READ, a, 8'h0);
      rd(FDATA_OFFS, v, r); chk("readback", d, v);
      dread(a, g); chk("direct", d, g);
    end
    dread(16'h0100, g); chk("direct", 0, g);
    $display("test program done");
    for (int c = 0; c < 2; c++) begin
      en = 1; wr(CTRL_OFFS, 32'h80);
      foreach (tm[k]) op(c[0], tm[k], ta[k], 8'($random(seed)));
      en = 0; wr(CTRL_OFFS, 32'h0); op(c[0], MODE_READ, 16'h7900, 8'h0);
      en = 1; wr(CTRL_OFFS, 32'h80); op(c[0], MODE_SP_WRITE, 16'h0003, 8'h71);
      dfLow = 16'h7000; rd(BOUND_OFFS, v, r); chk("bound", 32'h70, v);
      op(c[0], MODE_READ, 16'h7000, 8'h0);
      wr(CTRL_OFFS, c ? 32'ha0 : 32'he0);
      rst(0, 0); chk("softreset", c + 1, srN);
      dfLow = 16'h7800; rd(BOUND_OFFS, v, r); chk("bound", 32'h78, v);
      chk("boot", c ? 17'h0 : {1'b1, LDR}, {bootFromLoader, codeOffset});
      $display("test context %0d done", c);
    end
    hwLoaderBootOption <= 1; rst(0, 1); chk("ext", 0, bootFromLoader);
    rst(1, 0); chk("por", 1, bootFromLoader);
    hwLoaderBootOnExtResetOption <= 1; rst(0, 1); chk("ext2", 1, bootFromLoader);
    $display("test boot options done");
    testDone;
  end
endmodule : flash_prog_boot_ctrl_tb
